// file: logic/acq_seq_pkg.sv
/*
  Constants, register map and mode codes for the shutter-mode acquisition sequencer.
  Assumes a 125 MHz pclk and an APB master with 32-bit data.
*/
// Overview of operation
// - Outside card mode, bias stays on for the exposure and off during readout.
// - Normal allowed in self-paced and trigger modes; early bias in trigger and card modes.
// - Normal trigger mode: on trigger, bias for exposure, bias off, wait, read out.
// - Early bias: bias on when ready, off after exposure, re-bias before next trigger.
// - Self-paced: cycles back to back at top rate, trigger ignored.
// - Card mode needs no continuous flush, electronic shutter and falling-edge trigger.
// - Self-paced: flush before first exposure and after last readout only.
// - Exposure window output rises only after current and extra flushes complete.
// - Nonzero extra flush count adds that many full flushes; zero adds none.
// - Electronic shutter inserts a fixed 6 ms wait between bias off and readout.
// - Normal control with falling edge: bias on at trigger falling edge.
// - Early bias: bias on only after start, flushes done, window high.
// - No continuous flush, normal: flush until start, final flush, await trigger.
// - No continuous flush, early bias: after start, final flush, bias on, trigger integrates.
// - Continuous flush, normal: keep flushing, on trigger finish flush then bias on.
// - Continuous flush, early bias: bias on after final flush, finish flush after trigger.
// - Continuous flush: integration starts only after current flush completes.
// - A setting selects rising or falling trigger edge.
package acq_seq_pkg;
  localparam logic [11:0] ctrl_addr      = 12'h000;
  localparam logic [11:0] exposure_addr  = 12'h004;
  localparam logic [11:0] frames_addr    = 12'h008;
  localparam logic [11:0] flush_addr     = 12'h00c;
  localparam logic [11:0] status_addr    = 12'h010;
  localparam logic [11:0] done_addr      = 12'h014;
  // Control register field positions
  localparam int ctrl_start_bit   = 0;
  localparam int ctrl_mode_lsb    = 1;
  localparam int ctrl_early_bit   = 3;
  localparam int ctrl_cont_bit    = 4;
  localparam int ctrl_elec_bit    = 5;
  localparam int ctrl_neg_bit     = 6;
  localparam logic [31:0] ctrl_reset     = 32'h0000_0000;
  localparam logic [31:0] exposure_reset = 32'h0000_0001;
  localparam logic [31:0] frames_reset   = 32'h0000_0001;
  localparam logic [31:0] flush_reset    = 32'h0000_0000;
  localparam int clk_mhz        = 125;
  localparam int comp_wait_ms   = 6;
  localparam int comp_cycles    = comp_wait_ms * clk_mhz * 1000;
  localparam int flush_cycles_d = 1000;
  localparam int readout_cycles_d = 2000;
  typedef enum logic [1:0] {
    mode_self  = 2'b00,
    mode_trig  = 2'b01,
    mode_card  = 2'b10
  } acq_mode_t;
  typedef enum logic [2:0] {
    st_idle    = 3'b000,
    st_final   = 3'b001,
    st_wait    = 3'b010,
    st_finish  = 3'b011,
    st_expose  = 3'b100,
    st_comp    = 3'b101,
    st_readout = 3'b110,
    st_tail    = 3'b111
  } seq_state_t;
endpackage

// file: logic/shutter_mode_acquisition_sequencer.sv
/*
  Shutter-mode acquisition sequencer: flush, bias, exposure, compensation and readout timing.
  Assumes an APB master on pclk and an asynchronous trigger pin from outside.
*/
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module shutter_mode_acquisition_sequencer
  import acq_seq_pkg::*;
#(
  parameter int comp_count    = acq_seq_pkg::comp_cycles,
  parameter int flush_count   = acq_seq_pkg::flush_cycles_d,
  parameter int readout_count = acq_seq_pkg::readout_cycles_d
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_trigger,
  output logic             bias_on,
  output logic             exposure_window,
  output logic             flushing,
  output logic             reading_out
);
  import acq_seq_pkg::*;

  logic [31:0] ctrl;
  logic [31:0] exposure;
  logic [31:0] frames;
  logic [31:0] extra_flush_count;
  logic [31:0] frames_done;
  logic        cfg_error;
  logic [2:0]  trig_sync;
  logic        trig_level;
  logic [31:0] cnt;
  logic [31:0] extra_left;
  logic        running;
  logic        trig_pend;
  logic [31:0] comp_run;
  seq_state_t  state;
  seq_state_t  next_state;

  wire        wr_en       = psel & penable & pwrite;
  wire        addr_ok     = (paddr == ctrl_addr) | (paddr == exposure_addr) | (paddr == frames_addr) |
                            (paddr == flush_addr) | (paddr == status_addr) | (paddr == done_addr);
  wire        start_cmd   = wr_en & (paddr == ctrl_addr) & pwdata[ctrl_start_bit];
  // Start judged on the word written with it
  wire [31:0] cfg_word    = start_cmd ? pwdata : ctrl;
  wire [1:0]  cfg_mode    = cfg_word[ctrl_mode_lsb +: 2];
  wire [1:0]  mode        = ctrl[ctrl_mode_lsb +: 2];
  wire        early_bias  = ctrl[ctrl_early_bit];
  wire        cont_flush  = ctrl[ctrl_cont_bit];
  wire        elec_shut   = ctrl[ctrl_elec_bit];
  wire        neg_edge    = ctrl[ctrl_neg_bit];
  wire        is_self     = (mode == mode_self);
  wire        is_card     = (mode == mode_card);
  // Legal combinations of mode and shutter control
  wire        cfg_ok      = (cfg_mode != 2'b11) &
                            ~((cfg_mode == mode_self) & cfg_word[ctrl_early_bit]) &
                            ~((cfg_mode == mode_card) & (~cfg_word[ctrl_early_bit] | cfg_word[ctrl_cont_bit] |
                              ~cfg_word[ctrl_elec_bit] | ~cfg_word[ctrl_neg_bit]));
  // Edge seen once second and third stages agree
  wire        trig_new    = (trig_sync[1] == trig_sync[2]) & (trig_sync[1] != trig_level);
  wire        trig_edge   = trig_new & (neg_edge ? ~trig_sync[1] : trig_sync[1]) & ~is_self;
  wire        cnt_done    = (cnt == 32'h0000_0000);
  wire        last_frame  = (frames_done + 32'h0000_0001 >= frames);
  wire [31:0] comp_len    = elec_shut ? 32'(comp_count) : 32'h0000_0000;
  wire [31:0] exp_load    = (exposure == 32'h0000_0000) ? 32'h0000_0000 : exposure - 32'h0000_0001;
  wire [31:0] status_word = {24'h000000, cfg_error, running, 1'b0, state, bias_on, exposure_window};

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata  = (paddr == ctrl_addr)     ? ctrl :
                   (paddr == exposure_addr) ? exposure :
                   (paddr == frames_addr)   ? frames :
                   (paddr == flush_addr)    ? extra_flush_count :
                   (paddr == status_addr)   ? status_word :
                   (paddr == done_addr)     ? frames_done : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ctrl              <= ctrl_reset;
      exposure          <= exposure_reset;
      frames            <= frames_reset;
      extra_flush_count <= flush_reset;
    end
    else if (wr_en & ~running)
    begin
      if (paddr == ctrl_addr) ctrl <= {pwdata[31:1], 1'b0};
      if (paddr == exposure_addr) exposure <= pwdata;
      if (paddr == frames_addr) frames <= pwdata;
      if (paddr == flush_addr) extra_flush_count <= pwdata;
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      trig_sync  <= 3'b000;
      trig_level <= 1'b0;
    end
    else
    begin
      trig_sync <= {trig_sync[1:0], ext_trigger};
      if (trig_sync[1] == trig_sync[2]) trig_level <= trig_sync[1];
    end

  // Sequencer next state
  always_comb
  begin
    next_state = state;
    unique case (state)
      st_idle:    if (start_cmd & ~running & cfg_ok) next_state = st_final;
      st_final:   if (cnt_done & (extra_left == 32'h0000_0000))
                    next_state = is_self ? st_expose : (cont_flush ? st_finish : st_wait);
      st_wait:    if (trig_edge) next_state = st_expose;
      st_finish:  if (cnt_done & (trig_pend | trig_edge)) next_state = st_expose;
      st_expose:  if (cnt_done) next_state = st_comp;
      st_comp:    if (cnt_done) next_state = st_readout;
      st_readout: if (cnt_done) next_state = last_frame ? st_tail :
                                  (is_self ? st_expose : (cont_flush ? st_finish : st_wait));
      st_tail:    if (cnt_done) next_state = st_idle;
    endcase
  end

  // Timers and frame count
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      state       <= st_idle;
      cnt         <= 32'h0000_0000;
      extra_left  <= 32'h0000_0000;
      frames_done <= 32'h0000_0000;
      running     <= 1'b0;
      cfg_error   <= 1'b0;
      trig_pend   <= 1'b0;
      comp_run    <= 32'h0000_0000;
    end
    else
    begin
      state <= next_state;
      trig_pend <= (state == st_finish) & (next_state == st_finish) & (trig_pend | trig_edge);
      comp_run  <= (state == st_comp) ? comp_run + 32'h0000_0001 : 32'h0000_0000;
      if (start_cmd & ~running) cfg_error <= ~cfg_ok;
      unique case (state)
        st_idle:
        begin
          cnt <= cnt_done ? 32'(flush_count) : cnt - 32'h0000_0001;
          if (next_state == st_final)
          begin
            running     <= 1'b1;
            frames_done <= 32'h0000_0000;
            extra_left  <= extra_flush_count;
          end
        end
        st_final:
          if (cnt_done & (extra_left != 32'h0000_0000))
          begin
            cnt        <= 32'(flush_count);
            extra_left <= extra_left - 32'h0000_0001;
          end
          else if (cnt_done)
            cnt <= exp_load;
          else
            cnt <= cnt - 32'h0000_0001;
        st_wait:
          cnt <= exp_load;
        st_finish:
          // Continuous flush loops; on trigger the remaining flush time is spent first
          if (cnt_done) cnt <= (trig_pend | trig_edge) ? exp_load : 32'(flush_count);
          else cnt <= cnt - 32'h0000_0001;
        st_expose:
          cnt <= cnt_done ? comp_len : cnt - 32'h0000_0001;
        st_comp:
          cnt <= cnt_done ? 32'(readout_count) : cnt - 32'h0000_0001;
        st_readout:
          if (cnt_done)
          begin
            frames_done <= frames_done + 32'h0000_0001;
            cnt         <= last_frame ? 32'(flush_count) : (cont_flush ? 32'(flush_count) : exp_load);
          end
          else
            cnt <= cnt - 32'h0000_0001;
        st_tail:
          if (cnt_done) running <= 1'b0;
          else cnt <= cnt - 32'h0000_0001;
      endcase
    end

  // Exposure window high during exposure, also while armed with early bias
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      exposure_window <= 1'b0;
      bias_on         <= 1'b0;
      flushing        <= 1'b0;
      reading_out     <= 1'b0;
    end
    else
    begin
      exposure_window <= (next_state == st_expose) |
                         (early_bias & ((next_state == st_wait) | (next_state == st_finish)));
      // Bias on during exposure, early bias while armed, off for compensation and readout
      bias_on         <= (next_state == st_expose) |
                         (early_bias & ((next_state == st_wait) | (next_state == st_finish)));
      flushing        <= (next_state == st_idle) | (next_state == st_final) |
                         (next_state == st_finish) | (next_state == st_tail);
      reading_out     <= (next_state == st_readout);
    end

  chk_bias_off_readout: assert property (@(posedge pclk) disable iff (!presetn)
    reading_out |-> !bias_on) else $error("bias on during readout");
  chk_self_ignores_trig: assert property (@(posedge pclk) disable iff (!presetn)
    (is_self && state == st_idle) |-> !trig_edge) else $error("trigger seen in self mode");
  chk_comp_before_read: assert property (@(posedge pclk) disable iff (!presetn)
    (state == st_expose && next_state == st_comp) |=> !reading_out) else $error("readout without wait");
  chk_window_after_flush: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(exposure_window) |-> $past(state) != st_idle) else $error("window rose from idle");
  chk_end_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (state == st_tail && cnt_done) |=> (state == st_idle && !bias_on)) else $error("no return to idle");

  // Sequencer step checks
  sequence s_frame_end;
    (state == st_readout) && cnt_done;
  endsequence

  sequence s_trig_armed;
    (state == st_wait) && trig_edge;
  endsequence

  sequence s_flush_left;
    (state == st_final) && cnt_done && (extra_left != 32'h0000_0000);
  endsequence

  sequence s_finish_go;
    (state == st_finish) && cnt_done && (trig_pend || trig_edge);
  endsequence

  chk_trig_starts_expose: assert property (@(posedge pclk) disable iff (!presetn)
    s_trig_armed |=> (state == st_expose) && bias_on && exposure_window)
    else $error("trigger did not start exposure");

  chk_extra_flush_run: assert property (@(posedge pclk) disable iff (!presetn)
    s_flush_left |=> (state == st_final) && (cnt == 32'(flush_count)))
    else $error("extra flush not run");

  chk_finish_then_expose: assert property (@(posedge pclk) disable iff (!presetn)
    s_finish_go |=> (state == st_expose) && bias_on)
    else $error("no exposure after flush");

  chk_self_back_to_back: assert property (@(posedge pclk) disable iff (!presetn)
    s_frame_end ##0 (is_self && !last_frame) |=> (state == st_expose) && bias_on)
    else $error("self cycle not back to back");

  chk_last_to_tail: assert property (@(posedge pclk) disable iff (!presetn)
    s_frame_end ##0 last_frame |=> (state == st_tail) && flushing && !bias_on)
    else $error("no flush after last frame");

  chk_idle_dark: assert property (@(posedge pclk) disable iff (!presetn)
    (state == st_idle) |-> !bias_on && !exposure_window)
    else $error("bias on while idle");

  chk_normal_dark_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (!early_bias && (state == st_wait || state == st_finish)) |-> !bias_on)
    else $error("bias on before trigger");

  chk_early_armed: assert property (@(posedge pclk) disable iff (!presetn)
    (early_bias && (state == st_wait || state == st_finish)) |-> bias_on && exposure_window)
    else $error("early bias not armed");

  chk_expose_biased: assert property (@(posedge pclk) disable iff (!presetn)
    (state == st_expose) |-> bias_on && exposure_window)
    else $error("exposure without bias");

  chk_comp_dark: assert property (@(posedge pclk) disable iff (!presetn)
    (state == st_comp) |-> !bias_on && !reading_out)
    else $error("bias or readout in wait");

  chk_comp_length: assert property (@(posedge pclk) disable iff (!presetn)
    ((state == st_comp) && cnt_done) |-> (comp_run == comp_len))
    else $error("wait length wrong");

  chk_bad_cfg_refused: assert property (@(posedge pclk) disable iff (!presetn)
    (start_cmd && !running && !cfg_ok) |=> (state == st_idle) && cfg_error)
    else $error("illegal setup started");

  chk_window_needs_run: assert property (@(posedge pclk) disable iff (!presetn)
    exposure_window |-> running)
    else $error("window high while stopped");

  chk_final_dark: assert property (@(posedge pclk) disable iff (!presetn)
    (state == st_final) |-> !bias_on)
    else $error("bias on during final flush");
endmodule

// file: verification/trig_source.sv
/*
  Model of the external trigger source: one pulse per request.
  Assumes requests come from the bench on pclk.
*/
`timescale 1ns/1ps
module trig_source (
  input  wire logic pclk,
  input  wire logic fire,
  input  wire logic neg_edge,
  output logic      ext_trigger
);
  logic [2:0] cnt = 3'h0;
  // One pulse per exposure, active edge per polarity
  assign ext_trigger = neg_edge ? (cnt == 3'h0) : (cnt != 3'h0);
  always @(posedge pclk)
  begin
    if (fire)
      cnt <= 3'h6;
    else if (cnt != 3'h0)
      cnt <= cnt - 3'h1;
  end
endmodule

// file: verification/tb_shutter_mode_acquisition_sequencer.sv
/*
  Self-checking bench for the acquisition sequencer.
  Assumes APB with zero wait states and shortened counts.
*/
`timescale 1ns/1ps
module tb_shutter_mode_acquisition_sequencer;
  import acq_seq_pkg::*;
  localparam int comp_n = 20;
  typedef struct {logic [11:0] a; logic [31:0] d;} row_t;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, blen = 32'h0, gap = 32'h0;
  logic        pready, pslverr, er, ext_trigger, bias_on, exposure_window, flushing, reading_out;
  logic        fire = 1'b0, neg = 1'b1, bias_q = 1'b0, len_on = 1'b0;
  int          err_total = 0, num_checks = 0, cyc = 0, i;
  row_t        rows [4] = '{'{ctrl_addr, ctrl_reset}, '{exposure_addr, exposure_reset},
                            '{frames_addr, frames_reset}, '{flush_addr, flush_reset}};
  shutter_mode_acquisition_sequencer #(.comp_count(comp_n), .flush_count(10), .readout_count(10))
    shutter_mode_acquisition_sequencer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_trigger(ext_trigger), .bias_on(bias_on), .exposure_window(exposure_window),
    .flushing(flushing), .reading_out(reading_out));
  trig_source trig_source_i (.pclk(pclk), .fire(fire), .neg_edge(neg), .ext_trigger(ext_trigger));
  initial
  begin
    forever #4 pclk = ~pclk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task stop_test;
    if (err_total == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task wait_idle;
    do apb(1'b0, status_addr, 32'h0); while (rd[6] !== 1'b0);
  endtask
  task pulse;
    @(posedge pclk); fire <= 1'b1;
    @(posedge pclk); fire <= 1'b0;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_total++;
      stop_test;
    end
    blen <= bias_on ? blen + 32'h1 : 32'h0;
    bias_q <= bias_on;
    if (!bias_on && bias_q && len_on) chk(blen, 32'h5);
    if (bias_q && !bias_on) gap <= 32'h1;
    else if (gap != 32'h0 && !reading_out) gap <= gap + 32'h1;
    else if (gap != 32'h0)
    begin
      chk(32'(gap >= comp_n), 32'h1);
      gap <= 32'h0;
    end
    if (bias_on && reading_out) chk(32'h1, 32'h0);
  end
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 4; i++)
    begin
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].d);
    end
    apb(1'b0, 12'h020, 32'h0);
    chk(32'(er), 32'h1);
    chk(32'(bias_on), 32'h0);
    len_on = 1'b1;
    apb(1'b1, exposure_addr, 32'h5);
    apb(1'b1, frames_addr, 32'h2);
    apb(1'b1, flush_addr, 32'h1);
    apb(1'b1, ctrl_addr, 32'h21);
    pulse; // ignored while self-paced
    wait_idle;
    apb(1'b0, done_addr, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, frames_addr, 32'h1);
    apb(1'b1, ctrl_addr, 32'h63);
    repeat (80) @(posedge pclk);
    chk(32'(bias_on), 32'h0);
    pulse;
    for (i = 0; i < 80 && bias_on !== 1'b1; i++) @(posedge pclk);
    chk(32'(bias_on), 32'h1);
    wait_idle;
    chk(32'(bias_on), 32'h0);
    len_on = 1'b0;
    apb(1'b1, ctrl_addr, 32'h6b);
    for (i = 0; i < 100 && bias_on !== 1'b1; i++) @(posedge pclk);
    chk(32'(bias_on), 32'h1);
    chk(32'(exposure_window), 32'h1);
    pulse;
    wait_idle;
    apb(1'b0, done_addr, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, ctrl_addr, 32'h73);
    repeat (40) @(posedge pclk);
    chk(32'(bias_on), 32'h0);
    pulse;
    for (i = 0; i < 80 && bias_on !== 1'b1; i++) @(posedge pclk);
    chk(32'(bias_on), 32'h1);
    wait_idle;
    apb(1'b1, ctrl_addr, 32'h09);
    apb(1'b0, status_addr, 32'h0);
    chk({24'h0, rd[7:6]}, 32'h2);
    stop_test;
  end
endmodule
